/* src/sps_pkg.sv */
package sps_pkg;
	// ==========================================
	// Register addresses
	localparam logic [7:0] ADDR_CONFIG = 8'h9A;
	localparam logic [7:0] ADDR_DATA = 8'h9B;
	localparam logic [7:0] ADDR_CLOCK_RATE = 8'h9D;
	localparam logic [7:0] ADDR_CONTROL = 8'hF8;
	// ==========================================
	// Reset values
	localparam logic [7:0] CONFIG_RESET = 8'h07;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CLOCK_RATE_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// ==========================================
	// Configuration register fields
	localparam int CFG_PHASE_BIT = 7;
	localparam int CFG_POLARITY_BIT = 6;
	localparam int CFG_COUNT_HI = 5;
	localparam int CFG_COUNT_LO = 3;
	localparam int CFG_FRAME_HI = 2;
	localparam int CFG_FRAME_LO = 0;
	// ==========================================
	// Control register fields
	localparam int CTL_DONE_BIT = 7;
	localparam int CTL_COLLISION_BIT = 6;
	localparam int CTL_FAULT_BIT = 5;
	localparam int CTL_OVERRUN_BIT = 4;
	localparam int CTL_BUSY_BIT = 3;
	localparam int CTL_SELECTED_BIT = 2;
	localparam int CTL_MASTER_BIT = 1;
	localparam int CTL_ENABLE_BIT = 0;
	// ==========================================
	// Widths and states
	localparam int WORD_W = 8;
	localparam int COUNT_W = 3;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 3'h0;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 3'h1;
	localparam logic [7:0] DIV_ZERO = 8'h00;
	localparam logic [7:0] DIV_ONE = 8'h01;
	localparam logic [1:0] BUF_ONE = 2'h1;
	localparam logic [1:0] BUF_TWO = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_MASTER = 2'h1,
		ST_SLAVE = 2'h2
	} sps_state_e;
endpackage

/* src/sps_pair_buffer.sv */
`timescale 1ns/10ps
module sps_pair_buffer
	import sps_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clockEnable,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WORD_W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WORD_W-1:0] outData
);
	logic [1:0] count;
	logic [1:0] next_count;
	logic [WORD_W-1:0] second;
	logic [WORD_W-1:0] next_second;
	logic [WORD_W-1:0] next_outData;
	logic push;
	logic pop;

	// ==========================================
	// Two-entry queue, head always in outData
	always_comb begin
		push = inValid && inReady;
		pop = outValid && outReady;
		next_count = count;
		next_second = second;
		next_outData = outData;
		if (pop) begin
			next_outData = second;
			next_count = count - BUF_ONE;
		end
		if (push) begin
			next_count = next_count + BUF_ONE;
			if (next_count == BUF_ONE) begin
				next_outData = inData;
			end else begin
				next_second = inData;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= 2'h0;
			second <= DATA_RESET;
			outData <= DATA_RESET;
			outValid <= 1'b0;
			inReady <= 1'b1;
		end else if (clockEnable) begin
			count <= next_count;
			second <= next_second;
			outData <= next_outData;
			outValid <= next_count != 2'h0;
			inReady <= next_count != BUF_TWO;
		end
	end
endmodule

/* src/sps_port.sv */
`timescale 1ns/10ps
// Operation
// - Master-enable set makes a port master; data write starts transfer at once.
// - Master shifts out on MOSI, drives SCK, shifts MISO in simultaneously.
// - Transfer-complete flag set at each completed transfer end, not when port disable, master enable or a mode fault aborts it; software clears.
// - Frame size n gives n+1 bits in master mode; slave ignores it.
// - Data write during transfer dropped; write-collision flag set.
// - Data reads return receive buffer; writes go to shift register.
// - Unread receive buffer at transfer end: keep old, drop new, flag overrun.
// - Slave framed by select low; completes when select returns high.
// - Select low in master mode: fault flag, clear master and enable.
// - Slave-selected flag reads 1 while select pin is low.
// - Clock phase 0 samples first SCK edge, 1 samples second.
// - Clock polarity chooses SCK idle level, 0 low, 1 high.
// - Both ends share phase and polarity; change them while disabled.
// - Bit-count field reports index of bit being transferred.
// - Transmit-busy flag is 1 throughout a master transfer.
// - Port-enable bit turns port on; bit-addressable.
// - Clock-rate register only matters in master mode.
// - SCK is half system clock divided by clock rate plus one.
// - Both data lines shift most significant bit first.
// - Unselected slave keeps MISO undriven.
module sps_port
	import sps_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clockEnable,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic [7:0] sfrWriteData,
	input wire logic sfrRead,
	output logic [7:0] sfrReadData,
	input wire logic bitWrite,
	input wire logic [2:0] bitSelect,
	input wire logic bitValue,
	output logic irqRequest,
	output logic sckOut,
	output logic sckOe,
	input wire logic sckIn,
	output logic mosiOut,
	output logic mosiOe,
	input wire logic mosiIn,
	output logic misoOut,
	output logic misoOe,
	input wire logic misoIn,
	input wire logic slave_select_n,
	output logic rxWordValid,
	input wire logic rxWordReady,
	output logic [WORD_W-1:0] rxWord
);
	sps_state_e state, next_state;
	logic [WORD_W-1:0] shiftReg, next_shiftReg;
	logic [WORD_W-1:0] rxBuffer, next_rxBuffer;
	logic rxUnread, next_rxUnread;
	logic [COUNT_W-1:0] bit_count, next_bit_count;
	logic [7:0] divCount, next_divCount;
	logic firstHalf, next_firstHalf;
	logic clock_phase, next_clock_phase;
	logic clock_polarity, next_clock_polarity;
	logic [COUNT_W-1:0] frame_size, next_frame_size;
	logic [7:0] clockRate, next_clockRate;
	logic master_enable, next_master_enable;
	logic port_enable, next_port_enable;
	logic transfer_done_flag, next_transfer_done_flag;
	logic write_collision_flag, next_write_collision_flag;
	logic mode_fault_flag, next_mode_fault_flag;
	logic receive_overrun_flag, next_receive_overrun_flag;
	logic sckPrev, next_sckOut, next_mosiOut;
	logic [7:0] next_sfrReadData;
	logic pushValid;
	logic bufReady;
	logic leadEdge;
	logic trailEdge;
	logic sampleEdge;
	logic [7:0] configValue;
	logic [7:0] controlValue;

	// ==========================================
	// Register read views
	always_comb begin
		configValue = 8'h00;
		configValue[CFG_PHASE_BIT] = clock_phase;
		configValue[CFG_POLARITY_BIT] = clock_polarity;
		configValue[CFG_COUNT_HI:CFG_COUNT_LO] = bit_count;
		configValue[CFG_FRAME_HI:CFG_FRAME_LO] = frame_size;
		controlValue = 8'h00;
		controlValue[CTL_DONE_BIT] = transfer_done_flag;
		controlValue[CTL_COLLISION_BIT] = write_collision_flag;
		controlValue[CTL_FAULT_BIT] = mode_fault_flag;
		controlValue[CTL_OVERRUN_BIT] = receive_overrun_flag;
		controlValue[CTL_BUSY_BIT] = state == ST_MASTER;
		controlValue[CTL_SELECTED_BIT] = !slave_select_n;
		controlValue[CTL_MASTER_BIT] = master_enable;
		controlValue[CTL_ENABLE_BIT] = port_enable;
	end

	// ==========================================
	// Slave edge detection on the incoming clock
	always_comb begin
		leadEdge = (sckPrev == clock_polarity) && (sckIn != clock_polarity);
		trailEdge = (sckPrev != clock_polarity) && (sckIn == clock_polarity);
		sampleEdge = clock_phase ? trailEdge : leadEdge;
	end

	// ==========================================
	// Next-state logic
	always_comb begin
		next_state = state;
		next_shiftReg = shiftReg;
		next_rxBuffer = rxBuffer;
		next_rxUnread = rxUnread;
		next_bit_count = bit_count;
		next_divCount = divCount;
		next_firstHalf = firstHalf;
		next_clock_phase = clock_phase;
		next_clock_polarity = clock_polarity;
		next_frame_size = frame_size;
		next_clockRate = clockRate;
		next_master_enable = master_enable;
		next_port_enable = port_enable;
		next_transfer_done_flag = transfer_done_flag;
		next_write_collision_flag = write_collision_flag;
		next_mode_fault_flag = mode_fault_flag;
		next_receive_overrun_flag = receive_overrun_flag;
		next_sckOut = sckOut;
		next_mosiOut = mosiOut;
		next_sfrReadData = sfrReadData;
		pushValid = 1'b0;

		// Software side first so hardware sets below win
		if (sfrRead) begin
			case (sfrAddr)
				ADDR_CONFIG: next_sfrReadData = configValue;
				ADDR_CONTROL: next_sfrReadData = controlValue;
				ADDR_CLOCK_RATE: next_sfrReadData = clockRate;
				ADDR_DATA: begin
					next_sfrReadData = rxBuffer;
					next_rxUnread = 1'b0;
				end
				default: next_sfrReadData = 8'h00;
			endcase
		end
		if (sfrWrite) begin
			case (sfrAddr)
				ADDR_CONFIG: begin
					next_clock_phase = sfrWriteData[CFG_PHASE_BIT];
					next_clock_polarity = sfrWriteData[CFG_POLARITY_BIT];
					next_frame_size = sfrWriteData[CFG_FRAME_HI:CFG_FRAME_LO];
				end
				ADDR_CONTROL: begin
					next_transfer_done_flag = sfrWriteData[CTL_DONE_BIT];
					next_write_collision_flag = sfrWriteData[CTL_COLLISION_BIT];
					next_mode_fault_flag = sfrWriteData[CTL_FAULT_BIT];
					next_receive_overrun_flag = sfrWriteData[CTL_OVERRUN_BIT];
					next_master_enable = sfrWriteData[CTL_MASTER_BIT];
					next_port_enable = sfrWriteData[CTL_ENABLE_BIT];
				end
				ADDR_CLOCK_RATE: next_clockRate = sfrWriteData;
				ADDR_DATA: begin
					if (state != ST_IDLE || !bufReady) begin
						next_write_collision_flag = 1'b1;
					end else begin
						next_shiftReg = sfrWriteData;
						if (master_enable && port_enable) begin
							next_state = ST_MASTER;
							next_mosiOut = sfrWriteData[WORD_W-1];
							next_bit_count = COUNT_ZERO;
							next_divCount = DIV_ZERO;
							next_firstHalf = 1'b1;
						end
					end
				end
				default: ;
			endcase
		end
		if (bitWrite) begin
			case (bitSelect)
				3'h7: next_transfer_done_flag = bitValue;
				3'h6: next_write_collision_flag = bitValue;
				3'h5: next_mode_fault_flag = bitValue;
				3'h4: next_receive_overrun_flag = bitValue;
				3'h1: next_master_enable = bitValue;
				3'h0: next_port_enable = bitValue;
				default: ;
			endcase
		end

		case (state)
			ST_IDLE: begin
				next_sckOut = clock_polarity;
				if (port_enable && !master_enable && !slave_select_n) begin
					next_state = ST_SLAVE;
					next_bit_count = COUNT_ZERO;
				end
			end
			ST_MASTER: begin
				if (divCount == clockRate) begin
					next_divCount = DIV_ZERO;
					next_sckOut = !sckOut;
					next_firstHalf = !firstHalf;
					if (firstHalf != clock_phase) begin
						next_shiftReg = {shiftReg[WORD_W-2:0], misoIn};
					end else begin
						next_mosiOut = shiftReg[WORD_W-1];
					end
					if (!firstHalf) begin
						if (bit_count == frame_size) begin
							next_state = ST_IDLE;
							next_transfer_done_flag = 1'b1;
							pushValid = 1'b1;
						end else begin
							next_bit_count = bit_count + COUNT_ONE;
						end
					end
				end else begin
					next_divCount = divCount + DIV_ONE;
				end
			end
			ST_SLAVE: begin
				if (sampleEdge) begin
					next_shiftReg = {shiftReg[WORD_W-2:0], mosiIn};
				end
				if (trailEdge) begin
					next_bit_count = bit_count + COUNT_ONE;
				end
				if (slave_select_n) begin
					next_state = ST_IDLE;
					next_transfer_done_flag = 1'b1;
					pushValid = 1'b1;
				end else if (!port_enable || master_enable) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase

		// End of transfer: receive buffer and overrun
		if (pushValid) begin
			if (rxUnread || !bufReady) begin
				next_receive_overrun_flag = 1'b1;
			end else begin
				next_rxBuffer = next_shiftReg;
				next_rxUnread = 1'b1;
			end
		end

		// Another master selected this port while it is master
		if (master_enable && !slave_select_n) begin
			next_mode_fault_flag = 1'b1;
			next_master_enable = 1'b0;
			next_port_enable = 1'b0;
			next_state = ST_IDLE;
			next_sckOut = clock_polarity;
			pushValid = 1'b0;
		end
	end

	// ==========================================
	// Stream copy of each accepted word, except one whose last cycle meets a mode fault
	sps_pair_buffer u_rxQueue (
		.clock(clock),
		.rst_n(rst_n),
		.clockEnable(clockEnable),
		.inValid(pushValid && !rxUnread),
		.inReady(bufReady),
		.inData(next_shiftReg),
		.outValid(rxWordValid),
		.outReady(rxWordReady),
		.outData(rxWord)
	);

	// ==========================================
	// State registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			shiftReg <= DATA_RESET;
			rxBuffer <= DATA_RESET;
			rxUnread <= 1'b0;
			bit_count <= COUNT_ZERO;
			divCount <= DIV_ZERO;
			firstHalf <= 1'b1;
			clock_phase <= CONFIG_RESET[CFG_PHASE_BIT];
			clock_polarity <= CONFIG_RESET[CFG_POLARITY_BIT];
			frame_size <= CONFIG_RESET[CFG_FRAME_HI:CFG_FRAME_LO];
			clockRate <= CLOCK_RATE_RESET;
			master_enable <= CONTROL_RESET[CTL_MASTER_BIT];
			port_enable <= CONTROL_RESET[CTL_ENABLE_BIT];
			transfer_done_flag <= CONTROL_RESET[CTL_DONE_BIT];
			write_collision_flag <= CONTROL_RESET[CTL_COLLISION_BIT];
			mode_fault_flag <= CONTROL_RESET[CTL_FAULT_BIT];
			receive_overrun_flag <= CONTROL_RESET[CTL_OVERRUN_BIT];
			sckOut <= CONFIG_RESET[CFG_POLARITY_BIT];
			sckPrev <= CONFIG_RESET[CFG_POLARITY_BIT];
			sfrReadData <= 8'h00;
			irqRequest <= 1'b0;
			sckOe <= 1'b0;
			mosiOut <= 1'b0;
			mosiOe <= 1'b0;
			misoOut <= 1'b0;
			misoOe <= 1'b0;
		end else if (clockEnable) begin
			state <= next_state;
			shiftReg <= next_shiftReg;
			rxBuffer <= next_rxBuffer;
			rxUnread <= next_rxUnread;
			bit_count <= next_bit_count;
			divCount <= next_divCount;
			firstHalf <= next_firstHalf;
			clock_phase <= next_clock_phase;
			clock_polarity <= next_clock_polarity;
			frame_size <= next_frame_size;
			clockRate <= next_clockRate;
			master_enable <= next_master_enable;
			port_enable <= next_port_enable;
			transfer_done_flag <= next_transfer_done_flag;
			write_collision_flag <= next_write_collision_flag;
			mode_fault_flag <= next_mode_fault_flag;
			receive_overrun_flag <= next_receive_overrun_flag;
			sckOut <= next_sckOut;
			sckPrev <= sckIn;
			sfrReadData <= next_sfrReadData;
			irqRequest <= next_transfer_done_flag
				|| next_write_collision_flag || next_mode_fault_flag
				|| next_receive_overrun_flag;
			sckOe <= next_master_enable && next_port_enable;
			mosiOut <= next_mosiOut;
			mosiOe <= next_master_enable && next_port_enable;
			misoOut <= next_shiftReg[WORD_W-1];
			misoOe <= next_port_enable && !next_master_enable
				&& !slave_select_n;
		end
	end
endmodule

/* bench/sps_port_monitor.sv */
`timescale 1ns/10ps
// ==========
// Port checker
module sps_port_monitor
	import sps_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic [7:0] sfrWriteData,
	input wire logic sfrRead,
	input wire logic [7:0] sfrReadData,
	input wire logic bitWrite,
	input wire logic irqRequest,
	input wire logic sckOe,
	input wire logic misoOe,
	input wire logic slave_select_n,
	input wire logic rxWordValid,
	input wire logic rxWordReady,
	input wire logic [7:0] rxWord
);
	logic swWrite;
	assign swWrite = sfrWrite || bitWrite;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_MISO_RELEASE: assert property (
		slave_select_n [*3] |-> !misoOe) else $error("miso driven");
	AST_FAULT_DROPS_SCK: assert property (
		!slave_select_n && sckOe |-> ##[1:4] !sckOe) else $error("no fault");
	AST_ONE_ROLE: assert property (
		misoOe |-> !sckOe && !$past(slave_select_n))
		else $error("miso driven while not selected");
	AST_FLAG_SW_CLEAR: assert property ($fell(irqRequest) |->
		$past(swWrite) || $past(swWrite, 2) || $past(swWrite, 3))
		else $error("flag cleared without a write");
	AST_RX_HOLD: assert property (
		rxWordValid && !rxWordReady |=> rxWordValid && $stable(rxWord))
		else $error("stalled word lost");
	AST_SELECTED_FLAG: assert property (sfrRead &&
		sfrAddr == ADDR_CONTROL && $past(slave_select_n) == slave_select_n
		&& $past(slave_select_n, 2) == slave_select_n
		|=> sfrReadData[2] != $past(slave_select_n))
		else $error("selected flag wrong");
	AST_BUSY_MASTER: assert property (
		sfrRead && sfrAddr == ADDR_CONTROL |=> !sfrReadData[3] || sckOe)
		else $error("busy outside master");
	AST_CFG_READBACK: assert property (
		sfrWrite && sfrAddr == ADDR_CONFIG ##2 sfrRead && sfrAddr == ADDR_CONFIG
		|=> (sfrReadData & 8'hC7) == ($past(sfrWriteData, 3) & 8'hC7))
		else $error("config readback wrong");
endmodule

/* bench/sps_slave_model.sv */
`timescale 1ns/10ps
// ==========
// Far side serial slave
module sps_slave_model (
	input wire logic sckOut,
	input wire logic mosiOut,
	input wire logic sel,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [7:0] txWord,
	output logic misoIn,
	output logic [7:0] rxSeen
);
	logic [7:0] tx = 8'h00;
	initial rxSeen = 8'h00;
	// Word is in place before the frame opens
	always @(posedge sel) tx = txWord;
	// Sample and shift on the edges of the shared mode
	always @(sckOut) begin
		if (sel) begin
			if ((sckOut != cpol) != cpha) begin
				rxSeen = {rxSeen[6:0], mosiOut};
				if (cpha) tx = tx << 1;
			end else if (!cpha) begin
				tx = tx << 1;
			end
		end
	end
	// Released line shows the inverse of the next unsent bit, tx[7]
	assign misoIn = sel ? tx[7] : !tx[7];
endmodule

/* bench/spi_master_slave_port_test.sv */
`timescale 1ns/10ps
module spi_master_slave_port_test
	import sps_pkg::*;
;
	logic clock = 1'b0, rst_n = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0;
	logic bitWrite = 1'b0, bitValue = 1'b1, sckIn = 1'b0, mosiIn = 1'b0;
	logic slave_select_n = 1'b1, rxWordReady = 1'b1, sel = 1'b0;
	logic [2:0] bitSel = 3'h0;
	logic cpol = 1'b0, cpha = 1'b0;
	logic [7:0] sfrAddr = 8'h00, sfrWriteData = 8'h00, txWord = 8'h00;
	logic [7:0] rdv, sfrReadData, rxWord, rxSeen;
	logic irqRequest, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, misoIn;
	logic rxWordValid;
	int errorCnt = 0, checks = 0;
	sps_port i_dut (.clock, .rst_n, .clockEnable(1'b1), .sfrAddr, .sfrWrite,
		.sfrWriteData, .sfrRead, .sfrReadData, .bitWrite, .bitSelect(bitSel),
		.bitValue, .irqRequest, .sckOut, .sckOe, .sckIn, .mosiOut, .mosiOe,
		.mosiIn, .misoOut, .misoOe, .misoIn, .slave_select_n, .rxWordValid,
		.rxWordReady, .rxWord);
	sps_slave_model i_far (.sckOut, .mosiOut, .sel, .cpol, .cpha, .txWord,
		.misoIn, .rxSeen);
	initial forever #12.5 clock = ~clock;
	// ==========
	// Bus cycles
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfrAddr = a;
		sfrWriteData = d;
		sfrWrite = 1'b1;
		@(negedge clock);
		sfrWrite = 1'b0;
		@(negedge clock);
	endtask
	task rd(input logic [7:0] a);
		sfrAddr = a;
		sfrRead = 1'b1;
		@(negedge clock);
		sfrRead = 1'b0;
		rdv = sfrReadData;
		@(negedge clock);
	endtask
	task rc(input logic [7:0] a, input logic [7:0] e, input string what);
		rd(a);
		chk(what, rdv, e);
	endtask
	task xfer(input logic [7:0] t, input logic [7:0] d, input logic coll);
		txWord = t;
		sel = 1'b1;
		wr(ADDR_DATA, d);
		if (coll) wr(ADDR_DATA, 8'h11);
		rd(ADDR_CONTROL);
		chk("busy", rdv & 8'h08, 8'h08);
		rdv = 8'h00;
		for (int i = 0; i < 300 && rdv[7] !== 1'b1; i++) rd(ADDR_CONTROL);
		sel = 1'b0;
	endtask
	// ==========
	// Scenarios
	task masterModes;
		logic [2:0] m;
		logic [7:0] k;
		for (m = 3'h0; m < 3'h4; m++) begin
			k = {6'h00, m[1:0]};
			wr(ADDR_CONTROL, 8'h00);
			wr(ADDR_CONFIG, {m[1:0], 6'h07});
			rd(ADDR_CONFIG);
			cpha = m[1];
			cpol = m[0];
			wr(ADDR_CLOCK_RATE, {7'h00, m[0]});
			wr(ADDR_CONTROL, 8'h03);
			chk("sck idle", {7'h00, sckOut}, {7'h00, m[0]});
			chk("mosi oe", {7'h00, mosiOe}, 8'h01);
			xfer(8'h3C ^ k, 8'hA5 ^ k, 1'b1);
			chk("far rx", rxSeen, 8'hA5 ^ k);
			rc(ADDR_CONTROL, 8'hC3, "ctl done");
			chk("irq", {7'h00, irqRequest}, 8'h01);
			rc(ADDR_DATA, 8'h3C ^ k, "rx word");
		end
	endtask
	task frameOverrun;
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_CONFIG, 8'h03);
		rd(ADDR_CONFIG);
		cpha = 1'b0;
		cpol = 1'b0;
		wr(ADDR_CONTROL, 8'h03);
		rxWordReady = 1'b0;
		xfer(8'hB0, 8'hC0, 1'b0);
		chk("4 bit out", rxSeen & 8'h0F, 8'h0C);
		wr(ADDR_CONTROL, 8'h03);
		xfer(8'h70, 8'h50, 1'b0);
		rc(ADDR_CONTROL, 8'h93, "overrun");
		rd(ADDR_DATA);
		chk("kept", rdv & 8'h0F, 8'h0B);
		wr(ADDR_CONTROL, 8'h03);
		xfer(8'hE0, 8'h30, 1'b0);
		wr(ADDR_CONTROL, 8'h03);
		rd(ADDR_DATA);
		wr(ADDR_DATA, 8'hF0);
		rc(ADDR_CONTROL, 8'h43, "full refused");
		chk("stream 1", rxWord & 8'h0F, 8'h0B);
		rxWordReady = 1'b1;
		@(negedge clock);
		chk("stream 2", rxWord & 8'h0F, 8'h0E);
		@(negedge clock);
		chk("drained", {7'h00, rxWordValid}, 8'h00);
	endtask
	task faultAndBit;
		wr(ADDR_CONTROL, 8'h03);
		slave_select_n = 1'b0;
		repeat (4) @(negedge clock);
		rc(ADDR_CONTROL, 8'h24, "fault");
		slave_select_n = 1'b1;
		repeat (4) @(negedge clock);
		wr(ADDR_CONTROL, 8'h00);
		rc(ADDR_CONTROL, 8'h00, "fault clear");
		bitWrite = 1'b1;
		@(negedge clock);
		bitWrite = 1'b0;
		rc(ADDR_CONTROL, 8'h01, "bit write");
		bitSel = 3'h7;
		bitWrite = 1'b1;
		@(negedge clock);
		bitWrite = 1'b0;
		rc(ADDR_CONTROL, 8'h81, "bit set");
		bitValue = 1'b0;
		bitWrite = 1'b1;
		@(negedge clock);
		bitWrite = 1'b0;
		rc(ADDR_CONTROL, 8'h01, "bit clear");
	endtask
	task slaveFrame;
		logic [7:0] got;
		logic [7:0] sent;
		got = 8'h00;
		sent = 8'h5A;
		wr(ADDR_CONFIG, 8'h00);
		wr(ADDR_DATA, 8'h96);
		slave_select_n = 1'b0;
		repeat (4) @(negedge clock);
		chk("miso oe", {7'h00, misoOe}, 8'h01);
		for (int i = 7; i >= 0; i--) begin
			mosiIn = sent[i];
			repeat (4) @(negedge clock);
			got = {got[6:0], misoOut};
			sckIn = 1'b1;
			repeat (4) @(negedge clock);
			sckIn = 1'b0;
		end
		mosiIn = !mosiIn;
		repeat (4) @(negedge clock);
		slave_select_n = 1'b1;
		repeat (4) @(negedge clock);
		chk("miso", got, 8'h96);
		chk("miso off", {7'h00, misoOe}, 8'h00);
		rc(ADDR_CONTROL, 8'h81, "slave done");
		rc(ADDR_DATA, 8'h5A, "slave rx");
	endtask
	task tally_and_finish;
		if (errorCnt == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (10000) @(posedge clock);
		errorCnt++;
		tally_and_finish;
	end
	initial begin
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		@(negedge clock);
		rc(ADDR_CONFIG, CONFIG_RESET, "cfg reset");
		rc(ADDR_CONTROL, CONTROL_RESET, "ctl reset");
		rc(ADDR_CLOCK_RATE, CLOCK_RATE_RESET, "rate reset");
		rc(ADDR_DATA, DATA_RESET, "data reset");
		rc(8'h55, 8'h00, "unmapped");
		masterModes;
		frameOverrun;
		faultAndBit;
		slaveFrame;
		tally_and_finish;
	end
endmodule
bind sps_port sps_port_monitor i_mon (.clock, .rst_n, .sfrAddr, .sfrWrite,
	.sfrWriteData, .sfrRead, .sfrReadData, .bitWrite, .irqRequest, .sckOe,
	.misoOe, .slave_select_n, .rxWordValid, .rxWordReady, .rxWord);
